// ==== verilog/iqc_consts.svh ====
// register offsets, field positions and reset values of the
// invalidation queue setup registers; assumes byte addressing on a
// 32-bit classic Wishbone slave with word-aligned registers
`ifndef IQC_CONSTS_SVH
`define IQC_CONSTS_SVH

`define IQC_ADR_W          8
`define IQC_OFS_HEAD_LO    8'h80
`define IQC_OFS_HEAD_HI    8'h84
`define IQC_OFS_TAIL_LO    8'h88
`define IQC_OFS_TAIL_HI    8'h8C
`define IQC_OFS_QADDR_LO   8'h90
`define IQC_OFS_QADDR_HI   8'h94
`define IQC_OFS_WSTAT      8'h9C
`define IQC_OFS_EVCTL      8'hA0
`define IQC_OFS_CTRL       8'hB0
`define IQC_OFS_QSTAT      8'hB4
`define IQC_OFS_IRQ_STS    8'hB8
`define IQC_OFS_IRQ_MASK   8'hBC

`define IQC_QSIZE_MSB      2
`define IQC_QSIZE_LSB      0
`define IQC_BASE_LSB       12
`define IQC_PTR_MSB        18
`define IQC_PTR_LSB        4
`define IQC_WC_BIT         0
`define IQC_EVPEND_BIT     30
`define IQC_EVMASK_BIT     31
`define IQC_CTRL_EN_BIT    0
`define IQC_QSTAT_FEAT_BIT 0
`define IQC_QSTAT_EMPT_BIT 1
`define IQC_QSTAT_EN_BIT   2
`define IQC_EV_WAIT_BIT    0
`define IQC_EV_DRAIN_BIT   1

`define IQC_ENTRY_EXP_BASE 4'h8
`define IQC_EVMASK_RST     1'b1
`define IQC_IRQ_MASK_RST   2'h3

`endif

// ==== verilog/iqc_pkg.sv ====
// types shared by the invalidation queue register block;
// constants live in iqc_consts.svh
package iqc_pkg;
  `include "iqc_consts.svh"

  typedef logic [2:0]  iqc_qsize_t;
  typedef logic [14:0] iqc_ptr_t;

  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [`IQC_ADR_W-1:0]  adr;
    logic [3:0]             sel;
    logic [31:0]            dat;
  } iqc_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } iqc_wb_rsp_s;

  typedef struct packed {
    logic                   wr;
    logic [`IQC_ADR_W-1:0]  adr;
    logic [3:0]             sel;
    logic [31:0]            dat;
  } iqc_reg_acc_s;

  typedef enum logic [0:0] {
    IQC_BUS_IDLE = 1'b0,
    IQC_BUS_ACK  = 1'b1
  } iqc_bus_st_e;

  typedef struct packed {
    iqc_bus_st_e st;
    logic [31:0] dat;
  } iqc_bus_state_s;

  typedef struct packed {
    iqc_ptr_t head;
  } iqc_head_state_s;

  typedef struct packed {
    logic [51:0] base;
    iqc_qsize_t  qsize;
    iqc_ptr_t    tail;
    logic        en;
    logic        wc;
    logic        ev_mask;
    logic        ev_pend;
    logic [1:0]  irq_sts;
    logic [1:0]  irq_mask;
  } iqc_cfg_state_s;

  // entries = 2^(size+8), so the index mask is that minus one
  function automatic iqc_ptr_t iqc_entry_mask(input iqc_qsize_t qsize);
    logic [15:0] full;
    full = 16'h0001 << ({1'b0, qsize} + `IQC_ENTRY_EXP_BASE);
    return iqc_ptr_t'(full - 16'h0001);
  endfunction : iqc_entry_mask

  function automatic iqc_ptr_t iqc_wrap_inc(input iqc_ptr_t   ptr,
                                            input iqc_qsize_t qsize);
    return iqc_ptr_t'(ptr + 15'h0001) & iqc_entry_mask(qsize);
  endfunction : iqc_wrap_inc

  function automatic logic [31:0] iqc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction : iqc_merge
endpackage : iqc_pkg

// ==== verilog/iqc_wb_slave.sv ====
// classic Wishbone slave front end: acks one cycle after a request
// is seen and applies writes at the edge where ack is sampled;
// assumes the master holds the request until it sees ack
`timescale 1ns/10ps
module iqc_wb_slave
  (
    // clock and reset
    input  logic               mclk,
    input  logic               rst_n,
    // wishbone side
    input  iqc_pkg::iqc_wb_req_s  bus_req,
    output iqc_pkg::iqc_wb_rsp_s  bus_rsp,
    // register file side
    input  logic [31:0]        rd_data,
    output iqc_pkg::iqc_reg_acc_s acc
  );
  import iqc_pkg::*;

  iqc_bus_state_s st_ff;
  iqc_bus_state_s nxt_st;
  logic           req;

  assign req = bus_req.cyc && bus_req.stb;

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff.st)
      IQC_BUS_IDLE:
      begin
        // read data is captured here so it stays stable under ack
        if (req)
        begin
          nxt_st.st  = IQC_BUS_ACK;
          nxt_st.dat = rd_data;
        end
      end
      IQC_BUS_ACK:
        nxt_st.st = IQC_BUS_IDLE;
      default:
        nxt_st.st = IQC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign bus_rsp.ack = (st_ff.st == IQC_BUS_ACK) && req;
  assign bus_rsp.dat = st_ff.dat;
  assign acc.wr      = (st_ff.st == IQC_BUS_ACK) && req && bus_req.we;
  assign acc.adr     = bus_req.adr;
  assign acc.sel     = bus_req.sel;
  assign acc.dat     = bus_req.dat;
endmodule : iqc_wb_slave

// ==== verilog/iqc_head_ptr.sv ====
// descriptor fetch pointer of the invalidation queue;
// assumes adv is only raised while the queue is enabled and not empty
`timescale 1ns/10ps
module iqc_head_ptr
  (
    // clock and reset
    input  logic               mclk,
    input  logic               rst_n,
    // control
    input  logic               clr,
    input  logic               adv,
    input  iqc_pkg::iqc_qsize_t qsize,
    // state
    output iqc_pkg::iqc_ptr_t  head
  );
  import iqc_pkg::*;

  iqc_head_state_s st_ff;
  iqc_head_state_s nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (clr)
      nxt_st.head = '0;
    else if (adv)
      nxt_st.head = iqc_wrap_inc(st_ff.head, qsize);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign head = st_ff.head;
endmodule : iqc_head_ptr

// ==== verilog/iqc_regs.sv ====
// setup and completion-status registers of a queued invalidation
// unit, reached over classic Wishbone; assumes the descriptor engine
// pulses desc_fetch per consumed entry and wait_done per completed
// wait descriptor that asked for an interrupt
`timescale 1ns/10ps
`include "iqc_consts.svh"

// How it works
// - unsupported feature makes queue registers read zero, except the empty bit at 0xB4, which reads one
// - queue address write zeroes head and tail
// - base address in bits 63:12, 11:3 zero
// - base bits at or above address width ignored
// - base reads back last written implemented bits
// - size code X means 2^X pages
// - queue holds 2^(X+8) entries for wrapping
// - wait-complete flag set by hardware, write-one clears
// - without the feature the flag stays zero
// - head offset cleared while queue is disabled
// - new flag set raises pending, not if already set
// - mask withholds event message, pending kept
module iqc_regs
  #(
    parameter bit QI_SUPPORTED    = 1'b1,
    parameter int HOST_ADDR_WIDTH = 48
  )
  (
    // clock and reset
    input  logic                  mclk,
    input  logic                  rst_n,
    // register bus
    input  iqc_pkg::iqc_wb_req_s  bus_req,
    output iqc_pkg::iqc_wb_rsp_s  bus_rsp,
    // descriptor engine
    input  logic                  desc_fetch,
    input  logic                  wait_done,
    output logic [51:0]           queue_base_address,
    output iqc_pkg::iqc_qsize_t   queue_size_code,
    output iqc_pkg::iqc_ptr_t     head_offset,
    output iqc_pkg::iqc_ptr_t     tail_offset,
    output logic                  queue_enable,
    output logic                  queue_empty,
    // invalidation event message
    output logic                  evt_msg_valid,
    input  logic                  evt_msg_ready,
    // interrupt
    output logic                  irq
  );
  import iqc_pkg::*;

  // host address width wider than 64 still means all 64 bits
  localparam logic [63:0] ADDR_IMPL =
    (HOST_ADDR_WIDTH >= 64) ? 64'hFFFFFFFFFFFFFFFF :
    ((64'h0000000000000001 << HOST_ADDR_WIDTH) - 64'h0000000000000001);
  localparam logic [51:0] BASE_IMPL = ADDR_IMPL[63:`IQC_BASE_LSB];

  iqc_cfg_state_s cfg_ff;
  iqc_cfg_state_s nxt_cfg;
  iqc_reg_acc_s   acc;
  iqc_ptr_t       head;
  logic [31:0]    rd_data;
  logic [31:0]    wr_merged;
  logic [31:0]    wr_ones;
  logic           wr_qlo;
  logic           wr_qhi;
  logic           wr_tail;
  logic           wr_wstat;
  logic           wr_evctl;
  logic           wr_ctrl;
  logic           wr_ists;
  logic           wr_imask;
  logic           wc_set;
  logic           wc_clr;
  logic           msg_sent;
  logic           head_clr;
  logic           head_adv;
  logic           drained;
  logic [1:0]     ev_hit;

  iqc_wb_slave u_bus
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .bus_req (bus_req),
    .bus_rsp (bus_rsp),
    .rd_data (rd_data),
    .acc     (acc)
  );

  iqc_head_ptr u_head
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clr   (head_clr),
    .adv   (head_adv),
    .qsize (cfg_ff.qsize),
    .head  (head)
  );

  // read image of the addressed word; write data is merged into it
  always_comb
  begin
    rd_data = 32'h00000000;
    case (acc.adr)
      `IQC_OFS_HEAD_LO:
        rd_data[`IQC_PTR_MSB:`IQC_PTR_LSB] = head;
      `IQC_OFS_TAIL_LO:
        rd_data[`IQC_PTR_MSB:`IQC_PTR_LSB] = cfg_ff.tail;
      `IQC_OFS_QADDR_LO:
      begin
        rd_data[31:`IQC_BASE_LSB] = cfg_ff.base[19:0];
        rd_data[`IQC_QSIZE_MSB:`IQC_QSIZE_LSB] = cfg_ff.qsize;
      end
      `IQC_OFS_QADDR_HI:
        rd_data = cfg_ff.base[51:20];
      `IQC_OFS_WSTAT:
        rd_data[`IQC_WC_BIT] = cfg_ff.wc;
      `IQC_OFS_EVCTL:
      begin
        // the mask resets to one, so it alone must be hidden here
        rd_data[`IQC_EVMASK_BIT] = cfg_ff.ev_mask && QI_SUPPORTED;
        rd_data[`IQC_EVPEND_BIT] = cfg_ff.ev_pend;
      end
      `IQC_OFS_CTRL:
        rd_data[`IQC_CTRL_EN_BIT] = cfg_ff.en;
      `IQC_OFS_QSTAT:
      begin
        rd_data[`IQC_QSTAT_FEAT_BIT] = QI_SUPPORTED;
        rd_data[`IQC_QSTAT_EMPT_BIT] = queue_empty;
        rd_data[`IQC_QSTAT_EN_BIT]   = cfg_ff.en;
      end
      `IQC_OFS_IRQ_STS:
        rd_data[1:0] = cfg_ff.irq_sts;
      `IQC_OFS_IRQ_MASK:
        rd_data[1:0] = cfg_ff.irq_mask;
      default:
        rd_data = 32'h00000000;
    endcase
  end

  assign wr_merged = iqc_merge(rd_data, acc.dat, acc.sel);
  assign wr_ones   = iqc_merge(32'h00000000, acc.dat, acc.sel);

  // writes to queue registers are dropped when the feature is absent
  assign wr_qlo   = QI_SUPPORTED && acc.wr &&
                    (acc.adr == `IQC_OFS_QADDR_LO);
  assign wr_qhi   = QI_SUPPORTED && acc.wr &&
                    (acc.adr == `IQC_OFS_QADDR_HI);
  assign wr_tail  = QI_SUPPORTED && acc.wr &&
                    (acc.adr == `IQC_OFS_TAIL_LO);
  assign wr_wstat = QI_SUPPORTED && acc.wr &&
                    (acc.adr == `IQC_OFS_WSTAT);
  assign wr_evctl = QI_SUPPORTED && acc.wr &&
                    (acc.adr == `IQC_OFS_EVCTL);
  assign wr_ctrl  = QI_SUPPORTED && acc.wr &&
                    (acc.adr == `IQC_OFS_CTRL);
  assign wr_ists  = acc.wr && (acc.adr == `IQC_OFS_IRQ_STS);
  assign wr_imask = acc.wr && (acc.adr == `IQC_OFS_IRQ_MASK);

  assign wc_set   = QI_SUPPORTED && wait_done;
  assign wc_clr   = wr_wstat && wr_ones[`IQC_WC_BIT];
  assign msg_sent = evt_msg_valid && evt_msg_ready;

  // either half of the address register counts as a write to it
  assign head_clr = wr_qlo || wr_qhi || !cfg_ff.en;
  assign head_adv = desc_fetch && cfg_ff.en && !queue_empty;
  assign drained  = head_adv &&
                    (iqc_wrap_inc(head, cfg_ff.qsize) == cfg_ff.tail);

  assign ev_hit[`IQC_EV_WAIT_BIT]  = wc_set;
  assign ev_hit[`IQC_EV_DRAIN_BIT] = drained;

  always_comb
  begin
    nxt_cfg = cfg_ff;

    if (wr_qlo)
    begin
      // low base bits and size; the top bits are masked by width
      nxt_cfg.base[19:0] = wr_merged[31:`IQC_BASE_LSB] &
                           BASE_IMPL[19:0];
      nxt_cfg.qsize = wr_merged[`IQC_QSIZE_MSB:`IQC_QSIZE_LSB];
    end
    if (wr_qhi)
      nxt_cfg.base[51:20] = wr_merged & BASE_IMPL[51:20];

    if (wr_qlo || wr_qhi)
      nxt_cfg.tail = '0;
    else if (wr_tail)
      nxt_cfg.tail = wr_merged[`IQC_PTR_MSB:`IQC_PTR_LSB];

    if (wr_ctrl)
      nxt_cfg.en = wr_merged[`IQC_CTRL_EN_BIT];

    if (wr_evctl)
      nxt_cfg.ev_mask = wr_merged[`IQC_EVMASK_BIT];

    // a completion in the clearing cycle still leaves the flag set
    if (wc_set)
      nxt_cfg.wc = 1'b1;
    else if (wc_clr)
      nxt_cfg.wc = 1'b0;

    // pending rises only on a fresh flag; serviced by the message
    // going out or by software clearing the flag
    if (wc_set && !cfg_ff.wc)
      nxt_cfg.ev_pend = 1'b1;
    else if (msg_sent || (wc_clr && !wc_set))
      nxt_cfg.ev_pend = 1'b0;

    if (wr_imask)
      nxt_cfg.irq_mask = wr_merged[1:0];
    nxt_cfg.irq_sts = (cfg_ff.irq_sts &
                       ~(wr_ists ? wr_ones[1:0] : 2'h0)) | ev_hit;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cfg_ff          <= '0;
      cfg_ff.ev_mask  <= `IQC_EVMASK_RST;
      cfg_ff.irq_mask <= `IQC_IRQ_MASK_RST;
    end
    else
      cfg_ff <= nxt_cfg;
  end

  assign queue_base_address = cfg_ff.base;
  assign queue_size_code    = cfg_ff.qsize;
  assign head_offset        = head;
  assign tail_offset        = cfg_ff.tail;
  assign queue_enable       = cfg_ff.en;
  assign queue_empty        = (head == cfg_ff.tail);
  // held back while masked; pending stays up until serviced
  assign evt_msg_valid      = cfg_ff.ev_pend && !cfg_ff.ev_mask;
  assign irq                = |(cfg_ff.irq_sts & ~cfg_ff.irq_mask);
endmodule : iqc_regs

// ==== tb/iqc_regs_chk.sv ====
// checker for the invalidation queue register block
// sees only the ports of iqc_regs; bound at the foot of this file
`timescale 1ns/10ps
module iqc_regs_chk
  import iqc_pkg::*;
  #(
    parameter bit QI_SUPPORTED    = 1'b1,
    parameter int HOST_ADDR_WIDTH = 48
  )
  (
    // clock and reset
    input logic                 mclk,
    input logic                 rst_n,
    // register bus
    input iqc_pkg::iqc_wb_req_s bus_req,
    input iqc_pkg::iqc_wb_rsp_s bus_rsp,
    // engine side
    input logic                 desc_fetch,
    input logic                 wait_done,
    input logic [51:0]          queue_base_address,
    input iqc_pkg::iqc_qsize_t  queue_size_code,
    input iqc_pkg::iqc_ptr_t    head_offset,
    input iqc_pkg::iqc_ptr_t    tail_offset,
    input logic                 queue_enable,
    input logic                 queue_empty,
    input logic                 evt_msg_valid,
    input logic                 evt_msg_ready,
    input logic                 irq
  );
  logic        wr_ack;
  logic [14:0] msk;
  assign wr_ack = bus_rsp.ack && bus_req.we;
  assign msk    = 15'h7FFF >> (3'h7 - queue_size_code);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_ack_next;
    bus_req.cyc && bus_req.stb && !bus_rsp.ack |=> bus_rsp.ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_one;
    bus_rsp.ack |=> !bus_rsp.ack;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_qclr;
    QI_SUPPORTED && wr_ack && bus_req.adr[7:3] == 5'h12 |=>
      head_offset == 15'h0 && tail_offset == 15'h0;
  endproperty
  a_qclr: assert property (p_qclr) else $error("pointers kept");
  property p_rsvd;
    bus_rsp.ack && !bus_req.we && bus_req.adr == 8'h90 |->
      bus_rsp.dat[11:3] == 9'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("bits 11:3 set");
  property p_haw;
    (queue_base_address >> (HOST_ADDR_WIDTH - 12)) == 52'h0;
  endproperty
  a_haw: assert property (p_haw) else $error("base above width");
  property p_headdis;
    !queue_enable ##1 !queue_enable |-> head_offset == 15'h0;
  endproperty
  a_headdis: assert property (p_headdis) else $error("head kept");
  property p_noadv;
    queue_empty && queue_enable && !bus_rsp.ack |=> $stable(head_offset);
  endproperty
  a_noadv: assert property (p_noadv) else $error("empty moved");
  property p_wrap;
    QI_SUPPORTED && desc_fetch && queue_enable && !queue_empty &&
      !bus_rsp.ack |=>
      head_offset == (($past(head_offset) + 15'h1) & $past(msk));
  endproperty
  a_wrap: assert property (p_wrap) else $error("head step");
  property p_hold;
    evt_msg_valid && !evt_msg_ready && !wr_ack |=> evt_msg_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("event lost");
  property p_svc;
    evt_msg_valid && evt_msg_ready && !wait_done |=> !evt_msg_valid;
  endproperty
  a_svc: assert property (p_svc) else $error("event stuck");
  property p_rise;
    $rose(evt_msg_valid) |-> $past(wait_done) || $past(wr_ack);
  endproperty
  a_rise: assert property (p_rise) else $error("event uncaused");
endmodule : iqc_regs_chk

bind iqc_regs iqc_regs_chk #(
  .QI_SUPPORTED(QI_SUPPORTED), .HOST_ADDR_WIDTH(HOST_ADDR_WIDTH)
) i_chk (.mclk, .rst_n, .bus_req, .bus_rsp, .desc_fetch, .wait_done,
  .queue_base_address, .queue_size_code, .head_offset, .tail_offset,
  .queue_enable, .queue_empty, .evt_msg_valid, .evt_msg_ready, .irq);

// ==== tb/iqc_regs_tb.sv ====
// self-checking bench for iqc_regs over classic Wishbone; a second
// instance without the feature shares the bus and must read zero at 0x80 to 0xA0
`timescale 1ns/10ps
module iqc_regs_tb;
  import iqc_pkg::*;
  logic        mclk;
  logic        rst_n;
  iqc_wb_req_s bus_req;
  iqc_wb_rsp_s bus_rsp;
  iqc_wb_rsp_s rsp_nf;
  logic        desc_fetch;
  logic        wait_done;
  logic        evt_msg_ready;
  logic        evt_msg_valid;
  logic        irq;
  int          errors;
  int          n_checks;
  int          n;
  logic [31:0] exp_q[$];
  logic [31:0] d;

  iqc_regs i_dut (.mclk, .rst_n, .bus_req, .bus_rsp, .desc_fetch,
    .wait_done, .queue_base_address(), .queue_size_code(),
    .head_offset(), .tail_offset(), .queue_enable(), .queue_empty(),
    .evt_msg_valid, .evt_msg_ready, .irq);
  iqc_regs #(.QI_SUPPORTED(1'b0)) i_dut_nf (.mclk, .rst_n, .bus_req,
    .bus_rsp(rsp_nf), .desc_fetch, .wait_done, .queue_base_address(),
    .queue_size_code(), .head_offset(), .tail_offset(),
    .queue_enable(), .queue_empty(), .evt_msg_valid(),
    .evt_msg_ready, .irq());

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic fail(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_checks++;
    if (got !== e)
      fail($sformatf("got %h expected %h", got, e));
  endtask : chk
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // one bus cycle; entered and left just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] v);
    // only the watchdog ends a wait for ack
    bus_req <= '{1'b1, 1'b1, w, a, 4'hF, v};
    do
      @(posedge mclk);
    while (bus_rsp.ack !== 1'b1);
    bus_req <= '0;
    @(posedge mclk);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wb(1'b1, a, v);
  endtask : wr
  task automatic fetch(input int k);
    desc_fetch <= 1'b1;
    repeat (k) @(posedge mclk);
    desc_fetch <= 1'b0;
    @(posedge mclk);
  endtask : fetch
  task automatic pulse;
    wait_done <= 1'b1;
    @(posedge mclk);
    wait_done <= 1'b0;
    @(posedge mclk);
  endtask : pulse
  task automatic lvl(input logic s, input logic e);
    @(negedge mclk);
    chk({31'h0, s}, {31'h0, e});
    @(posedge mclk);
  endtask : lvl

  // read data is compared against the oldest note when ack shows
  // sampled at the ack edge, before that edge's updates land
  always @(posedge mclk)
    if (bus_rsp.ack === 1'b1 && bus_req.we === 1'b0)
    begin
      if (exp_q.size() == 0)
        fail("unexpected read");
      else
        chk(bus_rsp.dat, exp_q.pop_front());
      if (bus_req.adr >= 8'h80 && bus_req.adr <= 8'hA0)
        chk(rsp_nf.dat, 32'h0);
    end

  initial
  begin
    #(40 * 20000);
    fail("timeout");
    close_out;
  end

  initial
  begin
    rst_n = 1'b0;
    bus_req = '0;
    desc_fetch = 1'b0;
    wait_done = 1'b0;
    evt_msg_ready = 1'b0;
    errors = 0;
    n_checks = 0;
    d = $urandom(71760);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h90, 32'h0);
    rd(8'h9C, 32'h0);
    rd(8'hA0, 32'h8000_0000);
    rd(8'hBC, 32'h3);
    rd(8'hC0, 32'h0);
    $display("reset values done");
    d = $urandom;
    wr(8'h90, d);
    rd(8'h90, d & 32'hFFFF_F007);
    d = $urandom;
    wr(8'h94, d);
    rd(8'h94, d & 32'h0000_FFFF);
    $display("base address done");
    // size code 0 or 1 keeps the wrap walk short
    n = 256 << ($urandom % 2);
    wr(8'h90, 32'h0000_5000 | 32'(n >> 9));
    wr(8'hB0, 32'h1);
    wr(8'h88, 32'((n - 1) << 4));
    fetch(n + 4);
    rd(8'h80, 32'((n - 1) << 4));
    rd(8'hB4, 32'h7);
    rd(8'hB8, 32'h2);
    wr(8'h88, 32'h20);
    fetch(6);
    rd(8'h80, 32'h20);
    wr(8'hB0, 32'h0);
    rd(8'h80, 32'h0);
    wr(8'hB0, 32'h1);
    fetch(1);
    wr(8'h94, 32'h0);
    rd(8'h80, 32'h0);
    rd(8'h88, 32'h0);
    $display("queue walk done");
    wr(8'hB8, 32'h3);
    wr(8'hBC, 32'h0);
    wr(8'hA0, 32'h0);
    pulse;
    lvl(irq, 1'b1);
    lvl(evt_msg_valid, 1'b1);
    rd(8'h9C, 32'h1);
    rd(8'hA0, 32'h4000_0000);
    evt_msg_ready <= 1'b1;
    @(posedge mclk);
    evt_msg_ready <= 1'b0;
    @(posedge mclk);
    rd(8'hA0, 32'h0);
    pulse;
    rd(8'hA0, 32'h0);
    wr(8'h9C, 32'h1);
    rd(8'h9C, 32'h0);
    wr(8'hBC, 32'h1);
    lvl(irq, 1'b0);
    wr(8'hB8, 32'h1);
    wr(8'hBC, 32'h0);
    lvl(irq, 1'b0);
    wr(8'hA0, 32'h8000_0000);
    pulse;
    lvl(evt_msg_valid, 1'b0);
    rd(8'hA0, 32'hC000_0000);
    wr(8'hA0, 32'h0);
    lvl(evt_msg_valid, 1'b1);
    $display("events done");
    if (exp_q.size() != 0)
      fail("reads lost");
    close_out;
  end
endmodule : iqc_regs_tb
